// *** sbg_consts.vh ***
// constants for the serial baud rate generator
// Function
// R1: divisor is high register bits 4:0 over low register bits 7:0, thirteen bits.
// R2: high write is buffered; working divisor updates only on low register write.
// R3: divisor zero stops generator: no counting, no ticks.
// R4: divisor 1..8191 gives bit rate bus clock over sixteen times divisor.
// R5: low register resets non-zero; generator idle until receiver or transmitter enabled.
// R6: high bit 7 with line-break flag set requests interrupt.
// R7: high bit 6 with rx-pin edge flag set requests interrupt.
// R8: counter emits one oversample tick every divisor cycles, sixteen per bit.
`ifndef SBG_CONSTS_VH
`define SBG_CONSTS_VH
`define SBG_ADDR_W 3
`define SBG_OFS_BDH 3'h0
`define SBG_OFS_BDL 3'h1
`define SBG_OFS_CTL2 3'h2
`define SBG_OFS_STAT 3'h3
`define SBG_OFS_CLR 3'h4
`define SBG_OFS_IEN 3'h5
`define SBG_BDH_RST 8'h00
`define SBG_BDL_RST 8'h04
`define SBG_BIT_LBKIE 7
`define SBG_BIT_RXEIE 6
`define SBG_BIT_TE 3
`define SBG_BIT_RE 2
`define SBG_DIV_W 13
`define SBG_OVS_RATE 5'h10
`define SBG_NUM_EV 2
`endif

// *** sbg_tick_gen.v ***
// baud tick counter: oversample tick and bit tick
`timescale 1ns/1ps
`default_nettype none
`include "sbg_consts.vh"
module sbg_tick_gen (
  // clock and reset
  input wire clock,
  input wire rst_b,
  // control
  input wire run,
  input wire [`SBG_DIV_W-1:0] divisor,
  // ticks
  output reg ovs_tick_ff,
  output reg bit_tick_ff
);
  reg [`SBG_DIV_W-1:0] cnt_ff;
  reg [3:0] ovs_ff;
  wire active;
  wire hit;
  assign active = run && (divisor != 13'h0000); // R3
  assign hit = active && (cnt_ff >= divisor - 13'h0001); // R8
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 13'h0000;
      ovs_ff <= 4'h0;
      ovs_tick_ff <= 1'b0;
      bit_tick_ff <= 1'b0;
    end else if (!active) begin
      cnt_ff <= 13'h0000; // R3
      ovs_ff <= 4'h0;
      ovs_tick_ff <= 1'b0;
      bit_tick_ff <= 1'b0;
    end else begin
      cnt_ff <= hit ? 13'h0000 : cnt_ff + 13'h0001; // R8
      ovs_tick_ff <= hit;
      if (hit) begin
        ovs_ff <= ovs_ff + 4'h1; // R4
      end
      bit_tick_ff <= hit && (ovs_ff == 4'hf); // R4
    end
  end
endmodule // sbg_tick_gen
`default_nettype wire

// *** sbg_baud_gen.v ***
// serial baud rate generator with divisor registers and interrupt logic
`timescale 1ns/1ps
`default_nettype none
`include "sbg_consts.vh"
module sbg_baud_gen (
  // clock and reset
  input wire clock,
  input wire rst_b,
  // register port
  input wire [`SBG_ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata_ff,
  // event flags from receiver logic
  input wire line_break_detected_flag,
  input wire rx_pin_edge_flag,
  // outputs
  output wire ovs_tick,
  output wire bit_tick,
  output wire [`SBG_DIV_W-1:0] baud_divisor_value,
  output wire receiver_enable,
  output wire transmitter_enable,
  output wire irq
);
  reg [7:0] bdh_buf_ff;
  reg [4:0] bdh_work_ff;
  reg [7:0] bdl_ff;
  reg [7:0] ctl2_ff;
  reg started_ff;
  reg [`SBG_NUM_EV-1:0] stat_ff;
  reg [`SBG_NUM_EV-1:0] ien_ff;
  reg [`SBG_NUM_EV-1:0] ev_prev_ff;
  wire [`SBG_NUM_EV-1:0] ev_in;
  wire [`SBG_NUM_EV-1:0] ev_rise;
  wire wr_bdh;
  wire wr_bdl;
  wire wr_ctl2;
  wire wr_clr;
  wire wr_ien;
  wire line_break_irq_enable;
  wire rx_pin_edge_irq_enable;
  wire flag_irq;
  reg [7:0] nxt_rdata;
  genvar gi;

  assign wr_bdh = wr && (addr == `SBG_OFS_BDH);
  assign wr_bdl = wr && (addr == `SBG_OFS_BDL);
  assign wr_ctl2 = wr && (addr == `SBG_OFS_CTL2);
  assign wr_clr = wr && (addr == `SBG_OFS_CLR);
  assign wr_ien = wr && (addr == `SBG_OFS_IEN);

  assign baud_divisor_value = {bdh_work_ff, bdl_ff}; // R1
  assign receiver_enable = ctl2_ff[`SBG_BIT_RE];
  assign transmitter_enable = ctl2_ff[`SBG_BIT_TE];
  assign line_break_irq_enable = bdh_buf_ff[`SBG_BIT_LBKIE];
  assign rx_pin_edge_irq_enable = bdh_buf_ff[`SBG_BIT_RXEIE];

  // registers
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bdh_buf_ff <= `SBG_BDH_RST;
      bdh_work_ff <= 5'h00;
      bdl_ff <= `SBG_BDL_RST; // R5
      ctl2_ff <= 8'h00;
      ien_ff <= 2'h0;
    end else begin
      if (wr_bdh) begin
        bdh_buf_ff <= wdata; // R2
      end
      if (wr_bdl) begin
        bdl_ff <= wdata;
        bdh_work_ff <= bdh_buf_ff[4:0]; // R2
      end
      if (wr_ctl2) begin
        ctl2_ff <= wdata;
      end
      if (wr_ien) begin
        ien_ff <= wdata[`SBG_NUM_EV-1:0];
      end
    end
  end

  // generator stays idle after reset until a first enable write
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      started_ff <= 1'b0;
    end else if (wr_ctl2 && (wdata[`SBG_BIT_RE] || wdata[`SBG_BIT_TE])) begin
      started_ff <= 1'b1; // R5
    end
  end

  // sticky event status, set wins over clear
  assign ev_in = {rx_pin_edge_flag, line_break_detected_flag};
  generate
    for (gi = 0; gi < `SBG_NUM_EV; gi = gi + 1) begin : g_ev
      assign ev_rise[gi] = ev_in[gi] && !ev_prev_ff[gi];
      always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          ev_prev_ff[gi] <= 1'b0;
          stat_ff[gi] <= 1'b0;
        end else begin
          ev_prev_ff[gi] <= ev_in[gi];
          if (ev_rise[gi]) begin
            stat_ff[gi] <= 1'b1;
          end else if (wr_clr && wdata[gi]) begin
            stat_ff[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // direct flag requests plus masked sticky status
  assign flag_irq = (line_break_irq_enable && line_break_detected_flag) // R6
    || (rx_pin_edge_irq_enable && rx_pin_edge_flag); // R7
  assign irq = flag_irq || |(stat_ff & ien_ff);

  // read data one cycle after strobe
  always @* begin
    nxt_rdata = 8'h00;
    case (addr)
      `SBG_OFS_BDH: nxt_rdata = {bdh_buf_ff[7:6], 1'b0, bdh_buf_ff[4:0]};
      `SBG_OFS_BDL: nxt_rdata = bdl_ff;
      `SBG_OFS_CTL2: nxt_rdata = ctl2_ff;
      `SBG_OFS_STAT: nxt_rdata = {6'h00, stat_ff};
      `SBG_OFS_IEN: nxt_rdata = {6'h00, ien_ff};
      default: nxt_rdata = 8'h00;
    endcase
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= 8'h00;
    end else if (rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  sbg_tick_gen u_tick (
    .clock(clock),
    .rst_b(rst_b),
    .run(started_ff),
    .divisor(baud_divisor_value),
    .ovs_tick_ff(ovs_tick),
    .bit_tick_ff(bit_tick)
  );
endmodule // sbg_baud_gen
`default_nettype wire

// *** sbg_baud_gen_properties.sv ***
// port checker for the baud generator
`timescale 1ns/1ps
`default_nettype none
module sbg_props (
  // clock, reset and bus
  input wire logic clock, rst_b, wr,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  // generator and interrupt
  input wire logic ovs_tick, bit_tick, receiver_enable, transmitter_enable, irq,
  input wire logic line_break_detected_flag, rx_pin_edge_flag,
  input wire logic [12:0] baud_divisor_value
);
  logic on_ff;
  logic [3:0] n_ff;
  wire [12:0] dv = baud_divisor_value;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // set once the receiver or transmitter was enabled
  always @(posedge clock or negedge rst_b)
    if (!rst_b) on_ff <= 1'b0;
    else if (receiver_enable | transmitter_enable) on_ff <= 1'b1;
  // oversample ticks modulo sixteen
  always @(posedge clock or negedge rst_b)
    if (!rst_b) n_ff <= 4'h0;
    else if (ovs_tick) n_ff <= n_ff + 4'h1;
  sequence gap_s; !ovs_tick; endsequence
  low_a: assert property (wr && addr == 3'h1 |=> dv[7:0] == $past(wdata)) else $error("low");
  load_a: assert property ($changed(dv) |-> $past(wr && addr == 3'h1)) else $error("load");
  stop_a: assert property (dv == 0 && $past(dv) == 0 |-> !ovs_tick && !bit_tick) else $error("stop");
  div_two_a: assert property (ovs_tick && dv == 2 |=> gap_s ##1 (ovs_tick || dv != 2)) else $error("rate");
  idle_a: assert property (!on_ff |-> !ovs_tick) else $error("idle");
  en_a: assert property ($changed({receiver_enable, transmitter_enable}) |-> $past(wr && addr == 3'h2)) else $error("en");
  irq_a: assert property ($rose(irq) |-> $past(wr || line_break_detected_flag || rx_pin_edge_flag)
    || line_break_detected_flag || rx_pin_edge_flag) else $error("irq");
  bit_a: assert property (bit_tick |-> ovs_tick && n_ff == 4'hf) else $error("bit");
endmodule // sbg_props
bind sbg_baud_gen sbg_props u_props (.clock, .rst_b, .wr, .addr, .wdata, .ovs_tick, .bit_tick,
  .receiver_enable, .transmitter_enable, .irq, .line_break_detected_flag, .rx_pin_edge_flag, .baud_divisor_value);
`default_nettype wire

// *** sbg_baud_gen_tb.sv ***
// testbench for the baud generator
`timescale 1ns/1ps
`default_nettype none
`include "sbg_consts.vh"
module sbg_baud_gen_tb;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic brk = 1'b0;
  logic edg = 1'b0;
  wire [7:0] rdata_ff;
  wire [12:0] div;
  wire ovs_tick, bit_tick, irq;
  wire re, te;
  int err_count = 0;
  int total_checks = 0;
  int n_ovs = 0;
  int n_bit = 0;
  always #50 clock = ~clock;
  always @(posedge clock) begin
    n_ovs <= n_ovs + ovs_tick;
    n_bit <= n_bit + bit_tick;
  end
  sbg_baud_gen DUT (.clock, .rst_b, .addr, .wdata, .wr, .rd, .rdata_ff, .line_break_detected_flag(brk),
    .rx_pin_edge_flag(edg), .ovs_tick, .bit_tick, .baud_divisor_value(div), .receiver_enable(re),
    .transmitter_enable(te), .irq);
  task chk(input string what, input logic [12:0] seen, input logic [12:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task w(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask
  task r(input logic [2:0] a, input logic [7:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk("rdata", rdata_ff, e);
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #1000000;
    err_count++;
    end_of_test;
  end
  initial begin
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    r(`SBG_OFS_BDL, `SBG_BDL_RST);
    r(3'h6, 8'h00);
    w(`SBG_OFS_BDH, 8'h3f);
    chk("div", div, 13'h004);
    r(`SBG_OFS_BDH, 8'h1f);
    w(`SBG_OFS_BDL, 8'hff);
    chk("div", div, 13'h1fff);
    w(`SBG_OFS_BDH, 8'h00);
    w(`SBG_OFS_BDL, 8'h02);
    repeat (40) @(posedge clock);
    chk("idle", n_ovs[12:0], 13'h0);
    w(`SBG_OFS_CTL2, 8'h0c);
    chk("re", re, 13'h1);
    chk("te", te, 13'h1);
    repeat (4) @(posedge clock);
    #1 n_ovs = 0;
    n_bit = 0;
    repeat (320) @(posedge clock);
    #1;
    chk("ovs", n_ovs[12:0], 13'd160);
    chk("bit", n_bit[12:0], 13'd10);
    w(`SBG_OFS_BDL, 8'h00);
    repeat (2) @(posedge clock);
    #1 n_ovs = 0;
    repeat (50) @(posedge clock);
    chk("stop", n_ovs[12:0], 13'h0);
    for (int i = 0; i < 2; i++) begin
      @(posedge clock);
      {brk, edg} <= 2'b10 >> i;
      w(`SBG_OFS_BDH, 8'h00);
      chk("irq", irq, 13'h0);
      w(`SBG_OFS_BDH, 8'h80 >> i);
      chk("irq", irq, 13'h1);
      @(posedge clock);
      {brk, edg} <= 2'b00;
      w(`SBG_OFS_BDH, 8'h00);
      chk("irq", irq, 13'h0);
      r(`SBG_OFS_STAT, 8'h01 << i);
      w(`SBG_OFS_IEN, 8'h01 << i);
      chk("irq", irq, 13'h1);
      w(`SBG_OFS_CLR, 8'h03);
      chk("irq", irq, 13'h0);
      w(`SBG_OFS_IEN, 8'h00);
    end
    end_of_test;
  end
endmodule // sbg_baud_gen_tb
`default_nettype wire
